// ===== src/sodl_defs.svh
`ifndef SODL_DEFS_SVH
`define SODL_DEFS_SVH

// word layout
`define SODL_WORD_W 12
`define SODL_CODE_W 8
`define SODL_ADDR_W 4
`define SODL_NUM_CH 8
`define SODL_ADDR_MSB 3
`define SODL_CODE_TOP 11

// address values that select a channel
`define SODL_ADDR_FIRST 4'h1
`define SODL_ADDR_LAST 4'h8

// reset value of every channel code
`define SODL_CODE_RST 8'h00

// highest shift clock rate, in kHz
`define SODL_MAX_SHIFT_KHZ 2500

`endif

// ===== src/sodl_pkg.sv
`include "sodl_defs.svh"

package sodl_pkg;
  typedef logic [`SODL_WORD_W-1:0] sodl_word_t;
  typedef logic [`SODL_CODE_W-1:0] sodl_code_t;
  typedef logic [`SODL_ADDR_W-1:0] sodl_addr_t;
endpackage

// ===== src/sodl_loader.sv
`timescale 1ns/1ps
`include "sodl_defs.svh"

// Function
// - each rising shift clock edge shifts serial input into 12-bit register
// - cascade output always shows the shift register's top bit
// - load strobe rising edge copies the word into the addressed channel register
// - word is 4 address plus 8 code bits, fully shifted before load
// - code bit zero is least significant; code drives output level linearly
// - address read with last bit as LSB; values one to eight pick channels
// - eight 8-bit channel registers keep codes until addressed again
module sodl_loader (
  // system clock side
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  // serial link pins
  input wire logic shiftClk,
  input wire logic serial_in,
  input wire logic load_strobe,
  output logic serialOut,
  // channel codes to the converters
  output logic [`SODL_NUM_CH-1:0][`SODL_CODE_W-1:0] analog_channel_out,
  output logic loadDone
);

  // link domain: shift register clocked by the host's shift clock
  sodl_pkg::sodl_word_t shift_ff;
  sodl_pkg::sodl_word_t nxt_shift;

  // newest bit enters at the bottom, oldest moves to the top
  assign nxt_shift = {shift_ff[`SODL_WORD_W-2:0], serial_in};

  // no reset here: the host owns this domain and fills it in twelve clocks
  always_ff @(posedge shiftClk) begin
    shift_ff <= nxt_shift;
  end

  // cascade output, straight from the top flop
  assign serialOut = shift_ff[`SODL_WORD_W-1];

  // system domain: strobe synchroniser, edge detect and done pulse
  logic loadMeta_ff;
  logic loadSync_ff;
  logic loadPrev_ff;
  logic loadDone_ff;
  logic nxt_loadMeta;
  logic nxt_loadSync;
  logic nxt_loadPrev;
  logic nxt_loadDone;
  logic loadRise;

  // first flop of the synchroniser, read only by the second
  assign nxt_loadMeta = load_strobe;
  assign nxt_loadSync = loadMeta_ff;
  assign nxt_loadPrev = loadSync_ff;

  // a held strobe gives one rising edge, hence one load
  assign loadRise = loadSync_ff & ~loadPrev_ff;
  assign nxt_loadDone = loadRise;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      loadMeta_ff <= 1'b0;
    end else if (clkEn) begin
      loadMeta_ff <= nxt_loadMeta;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      loadSync_ff <= 1'b0;
    end else if (clkEn) begin
      loadSync_ff <= nxt_loadSync;
    end
  end

  // cleared by reset to the idle level, so no false edge follows it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      loadPrev_ff <= 1'b0;
    end else if (clkEn) begin
      loadPrev_ff <= nxt_loadPrev;
    end
  end

  // pulses for every load, also for don't-care addresses
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      loadDone_ff <= 1'b0;
    end else if (clkEn) begin
      loadDone_ff <= nxt_loadDone;
    end
  end

  assign loadDone = loadDone_ff;

  // word crossing: the shift clock idles while the strobe is high, so
  // the word holds still while the synchronised edge samples it
  sodl_pkg::sodl_addr_t wordAddr;
  sodl_pkg::sodl_code_t wordCode;
  sodl_pkg::sodl_addr_t chanIdx;
  logic addrLow;
  logic addrHigh;
  logic addrValid;
  logic [`SODL_NUM_CH-1:0] chanSel;
  logic [`SODL_NUM_CH-1:0] chanWe;

  // last bit shifted is the address lsb
  assign wordAddr = shift_ff[`SODL_ADDR_MSB:0];

  // don't-care addresses select nothing
  assign addrLow = (wordAddr >= `SODL_ADDR_FIRST);
  assign addrHigh = (wordAddr <= `SODL_ADDR_LAST);
  assign addrValid = addrLow & addrHigh;

  // address one picks index zero
  assign chanIdx = wordAddr - `SODL_ADDR_FIRST;

  genvar gi;

  // code field, reversed out of the shift register
  generate
    for (gi = 0; gi < `SODL_CODE_W; gi = gi + 1) begin : g_code
      // first bit in is code bit zero
      assign wordCode[gi] = shift_ff[`SODL_CODE_TOP-gi];
    end
  endgenerate

  // one-hot channel select
  generate
    for (gi = 0; gi < `SODL_NUM_CH; gi = gi + 1) begin : g_sel
      assign chanSel[gi] = addrValid &&
                           (chanIdx == sodl_pkg::sodl_addr_t'(gi));
      assign chanWe[gi] = loadRise & chanSel[gi];
    end
  endgenerate

  // channel code registers
  logic [`SODL_NUM_CH-1:0][`SODL_CODE_W-1:0] chan_ff;
  logic [`SODL_NUM_CH-1:0][`SODL_CODE_W-1:0] nxt_chan;

  generate
    for (gi = 0; gi < `SODL_NUM_CH; gi = gi + 1) begin : g_chan
      // unaddressed channels keep their code
      assign nxt_chan[gi] = chanWe[gi] ? wordCode : chan_ff[gi];

      always_ff @(posedge clk_sys) begin
        if (reset) begin
          chan_ff[gi] <= `SODL_CODE_RST;
        end else if (clkEn) begin
          chan_ff[gi] <= nxt_chan[gi];
        end
      end
    end
  endgenerate

  // codes leave straight from the channel flops
  assign analog_channel_out = chan_ff;

endmodule

// ===== bench/sodl_loader_sva.sv
`timescale 1ns/1ps
module sodl_loader_sva (
  input wire logic clk_sys, reset, shiftClk, serial_in, load_strobe,
  input wire logic serialOut, loadDone,
  input wire logic [7:0][7:0] analog_channel_out
);
  logic [3:0] n = 4'h0;
  always_ff @(posedge shiftClk) if (n != 4'hF) n <= n + 4'h1;
  sequence s_rise;
    $rose(load_strobe);
  endsequence
  sequence s_done;
    ##3 loadDone;
  endsequence
  property p_sh;
    @(posedge shiftClk) n > 4'hC |-> serialOut == $past(serial_in, 12);
  endproperty
  property p_ld;
    @(posedge clk_sys) disable iff (reset) s_rise |-> s_done;
  endproperty
  property p_rst;
    @(posedge clk_sys) reset |=> (analog_channel_out == 64'h0) && !loadDone;
  endproperty
  property p_src;
    @(posedge clk_sys) disable iff (reset)
      loadDone |-> $past(load_strobe, 3) && !$past(load_strobe, 4);
  endproperty
  property p_one;
    @(posedge clk_sys) disable iff (reset) loadDone |=> !loadDone;
  endproperty
  property p_ch;
    @(posedge clk_sys) disable iff (reset)
      $changed(analog_channel_out) |-> ##[0:1] loadDone;
  endproperty
  a_sh: assert property (p_sh) else $error("cascade");
  a_ld: assert property (p_ld) else $error("load");
  a_one: assert property (p_one) else $error("done");
  a_ch: assert property (p_ch) else $error("hold");
  a_rst: assert property (p_rst) else $error("reset");
  a_src: assert property (p_src) else $error("strobe");
endmodule
bind sodl_loader sodl_loader_sva u_sodl_loader_sva (.*);

// ===== bench/sodl_host.sv
`timescale 1ns/1ps
module sodl_host (
  input wire logic clk_sys,
  output logic sc = 0,
  output logic sd = 0,
  output logic ld = 0
);
  task automatic send(logic [3:0] a, logic [7:0] c);
    for (int i = 0; i < 12; i++) begin
      sd <= i < 8 ? c[i] : a[11-i];
      #16 sc <= 1'b1;
      #16 sc <= 1'b0;
    end
    sd <= 1'b0;
    @(posedge clk_sys) ld <= 1;
    repeat (6) @(posedge clk_sys);
    ld <= 0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule

// ===== bench/serial_octal_dac_loader_tb_top.sv
`timescale 1ns/1ps
module serial_octal_dac_loader_tb_top;
  logic clk_sys = 0, reset = 1, sc, sd, ld, so, done;
  logic [7:0][7:0] ch, ex = '0;
  logic [7:0] r = 8'h2C;
  logic [7:0] code;
  logic [63:0] q[$];
  int fail_count = 0, compares = 0;
  initial forever #12.5 clk_sys = ~clk_sys;
  sodl_loader u_sodl_loader (.clk_sys, .reset, .clkEn(1'b1),
    .shiftClk(sc), .serial_in(sd), .load_strobe(ld), .serialOut(so),
    .analog_channel_out(ch), .loadDone(done));
  sodl_host u_sodl_host (.clk_sys, .sc, .sd, .ld);
  function automatic logic [7:0] nx(logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task test_done;
    $display("compares %0d fails %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(logic [63:0] e);
    compares++;
    if (ch !== e) begin
      fail_count++;
      $display("Error channels exp %h got %h", e, ch);
    end
  endtask
  task chk_so(logic e);
    compares++;
    if (so !== e) begin
      fail_count++;
      $display("Error serialOut exp %b got %b", e, so);
    end
  endtask
  always @(posedge clk_sys) if (done === 1'b1) chk(q.pop_front());
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 0;
    for (int i = 0; i < 24; i++) begin
      r = nx(r);
      code = nx(r);
      if (r[3:0] inside {[1:8]}) ex[r[3:0]-4'h1] = code;
      q.push_back(ex);
      u_sodl_host.send(r[3:0], code);
      chk_so(code[0]);
      r = nx(r);
    end
    repeat (8) @(posedge clk_sys);
    if (q.size() != 0) fail_count++;
    $display("random loads done");
    test_done;
  end
endmodule
